//--- verif/cpu_register_ram_transfer_ops_tb_top.sv
// Self-checking bench for the transfer execution unit with a reference model.
// Assumes the RAM model in rtx_ram_model and the constants of rtx_pkg.
`timescale 1ns/1ps
`default_nettype none
module cpu_register_ram_transfer_ops_tb_top;
  import rtx_pkg::*;
  logic       clk;
  logic       rstn;
  logic       valid;
  logic [9:0] instr;
  logic [2:0] sp;
  logic [3:0] acc, b, x, y, wdata, rdata;
  logic [1:0] z;
  logic [7:0] e;
  logic [9:0] dp, waddr;
  logic       we, skip;
  logic [3:0] ea, eb, ex, ey;
  logic [1:0] ez;
  logic [7:0] ee;
  logic       esk, elxy;
  logic [3:0] em [0:1023];
  int         num_errors, check_count, cycles;

  rtx_core DUT (.clk_i(clk), .rstn_i(rstn), .instr_valid_i(valid), .instr_i(instr), .stack_ptr_i(sp),
    .ram_rdata_i(rdata), .acc_o(acc), .b_o(b), .x_o(x), .y_o(y), .z_o(z), .e_o(e), .data_pointer_o(dp),
    .ram_we_o(we), .ram_waddr_o(waddr), .ram_wdata_o(wdata), .skip_pending_o(skip));
  rtx_ram_model ram (.clk_i(clk), .raddr_i(dp), .we_i(we), .waddr_i(waddr), .wdata_i(wdata), .rdata_o(rdata));

  always #10 clk = ~clk;

  // ==========================================================================
  // Checking and driving
  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (num_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic reset_all();
    rstn = 1'b0;
    valid = 1'b0;
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    {ea, eb, ex, ey, ez, ee, esk, elxy} = '0;
    chk({acc, b, x, y, z, e, skip, we}, 28'h0);
  endtask

  // Predicts one instruction, issues it and compares every register output.
  task automatic step(input logic [9:0] w);
    logic [9:0] adr;
    logic [3:0] oa;
    logic       ewe;
    adr = {ez, ex, ey};
    oa = ea;
    ewe = 1'b0;
    if (esk) begin
      esk = 1'b0;
      elxy = (w[9:8] == RTX_PFX_LOAD_X_Y);
    end else if (w[9:8] == RTX_PFX_LOAD_X_Y) begin
      if (!elxy) {ex, ey} = w[7:0];
      elxy = 1'b1;
    end else begin
      elxy = 1'b0;
      casez (w)
        10'h01E: ea = eb;
        10'h00E: eb = ea;
        10'h01F: ea = ey;
        10'h00C: ey = ea;
        10'h01A: ee = {eb, ea};
        10'h02A: {eb, ea} = ee;
        10'h053: ea = {2'h0, ez};
        10'h052: ea = ex;
        10'h050: ea = {1'h0, sp};
        10'h013: begin ey = ey + 4'h1; esk = (ey == 4'h0); end
        10'h017: begin ey = ey - 4'h1; esk = (ey == 4'hF); end
        10'h048, 10'h049, 10'h04A, 10'h04B: ez = w[1:0];
        10'h2C?: ea = em[adr];
        10'h2B?: ewe = 1'b1;
        10'h2D?: begin ea = em[adr]; ewe = 1'b1; end
        10'h2F?: begin ea = em[adr]; ewe = 1'b1; ey = ey - 4'h1; esk = (ey == 4'hF); end
        10'h2E?: begin ea = em[adr]; ewe = 1'b1; ey = ey + 4'h1; esk = (ey == 4'h0); end
        default: ;
      endcase
      if (w[9:6] == 4'hB || w[9:4] == 6'h2B) ex = ex ^ w[3:0];
      if (ewe) em[adr] = oa;
    end
    instr = w;
    valid = 1'b1;
    @(posedge clk);
    #1;
    chk({acc, b, x, y, z, e, skip, we}, {ea, eb, ex, ey, ez, ee, esk, ewe});
    if (ewe) chk(28'({waddr, wdata}), 28'({adr, oa}));
  endtask

  task automatic idle();
    valid = 1'b0;
    @(posedge clk);
    #1;
    chk({acc, b, x, y, z, e, skip, we}, {ea, eb, ex, ey, ez, ee, esk, 1'b0});
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_pair_load();
    step(10'h3A5);
    step(10'h3FF);
    step(10'h3C3);
    step(10'h052);
    step(10'h30F);
    step(10'h000);
    step(10'h3C3);
    idle();
  endtask

  task automatic t_moves();
    for (int k = 0; k < 4; k++) step(10'h048 + 10'(k));
    step(10'h3A5);
    step(10'h052);
    step(10'h053);
    step(10'h052);
    step(10'h050);
    sp = 3'h2;
    step(10'h050);
    step(10'h052);
    step(10'h00E);
    step(10'h01F);
    step(10'h01A);
    step(10'h053);
    step(10'h00C);
    step(10'h01E);
    step(10'h01F);
    step(10'h00E);
    step(10'h02A);
  endtask

  task automatic t_steps();
    step(10'h30F);
    step(10'h013);
    step(10'h052);
    step(10'h013);
    step(10'h017);
    step(10'h017);
    idle();
    step(10'h3FF);
    step(10'h312);
    step(10'h052);
  endtask

  task automatic t_ram();
    step(10'h04A);
    step(10'h3A5);
    step(10'h2C3);
    step(10'h2D6);
    step(10'h2B9);
    step(10'h2F0);
    step(10'h390);
    step(10'h2F1);
    step(10'h01E);
    step(10'h39F);
    step(10'h2E2);
    step(10'h2C0);
    step(10'h395);
    step(10'h2C0);
    step(10'h01E);
    step(10'h2D0);
    step(10'h2D0);
    step(10'h2B0);
    step(10'h2C0);
    idle();
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    valid = 1'b0;
    instr = 10'h000;
    sp = 3'h7;
    num_errors = 0;
    check_count = 0;
    cycles = 0;
    for (int i = 0; i < 1024; i++) em[i] = 4'(i ^ (i >> 4) ^ (i >> 8));
    reset_all();
    t_pair_load();
    t_moves();
    reset_all();
    t_steps();
    t_ram();
    final_report();
  end
endmodule
`default_nettype wire

//--- verif/rtx_ram_model.sv
// Behavioural data RAM standing behind the transfer execution unit.
// Assumes a combinational read at the data pointer and a write on the clock edge.
`timescale 1ns/1ps
`default_nettype none
module rtx_ram_model (
  input  wire logic                           clk_i,
  input  wire logic [rtx_pkg::RTX_ADDR_W-1:0] raddr_i,
  input  wire logic                           we_i,
  input  wire logic [rtx_pkg::RTX_ADDR_W-1:0] waddr_i,
  input  wire logic [rtx_pkg::RTX_NIB_W-1:0]  wdata_i,
  output logic      [rtx_pkg::RTX_NIB_W-1:0]  rdata_o
);
  import rtx_pkg::*;
  logic [RTX_NIB_W-1:0] mem [0:(1<<RTX_ADDR_W)-1];
  // The fill pattern gives neighbouring words different values, except where X steps from 7 to 8 (0x07F and 0x080 both hold 8).
  initial begin
    for (int i = 0; i < (1 << RTX_ADDR_W); i++) begin
      mem[i] = 4'(i ^ (i >> 4) ^ (i >> 8));
    end
  end
  assign rdata_o = mem[raddr_i];
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end
endmodule
`default_nettype wire

//--- verilog/rtx_core.sv
// Execution unit for register moves, RAM address loads and RAM transfers.
// Assumes one instruction per valid cycle and a RAM that reads combinationally
// at the address shown on data_pointer_o.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Z-to-accumulator move fills bits 1..0 from Z and clears bits 3..2.
// - X-to-accumulator move copies X into the accumulator; X keeps its value.
// - Stack pointer read fills accumulator bits 2..0, bit 3 becomes zero.
// - Top two opcode bits set means pair load: bits 7..4 to X, 3..0 to Y.
// - In a run of back-to-back pair loads only the first one executes.
// - Z immediate load writes instruction bits 1..0 into Z.
// - Y increment wraps at 16 and skips the next instruction on zero.
// - Y decrement subtracts one modulo 16.
// - Any Y decrement that leaves fifteen skips the following instruction.
// - RAM load puts the addressed word in the accumulator, then X ^= j.
// - RAM exchange swaps accumulator and addressed word, then X ^= j.
// - Exchange with decrement swaps, applies X ^= j and decrements Y.
// - Exchange with increment swaps, applies X ^= j, increments Y with skip.
// - RAM store writes the accumulator to the addressed word, then X ^= j.
// - B-to-accumulator move copies B; B keeps its value.
// - Accumulator-to-B move copies the accumulator; accumulator unchanged.
// - Y-to-accumulator and accumulator-to-Y moves copy between the two.
// - Pair-to-E move puts B in E high nibble and accumulator in low nibble.
// - E-to-pair move puts E high nibble in B and low nibble in accumulator.
module rtx_core #(
  parameter int NIB_W = rtx_pkg::RTX_NIB_W
) (
  input  wire logic                           clk_i,
  input  wire logic                           rstn_i,
  input  wire logic                           instr_valid_i,
  input  wire logic [rtx_pkg::RTX_INSTR_W-1:0] instr_i,
  input  wire logic [rtx_pkg::RTX_SP_W-1:0]   stack_ptr_i,
  input  wire logic [rtx_pkg::RTX_NIB_W-1:0]  ram_rdata_i,
  output logic      [rtx_pkg::RTX_NIB_W-1:0]  acc_o,
  output logic      [rtx_pkg::RTX_NIB_W-1:0]  b_o,
  output logic      [rtx_pkg::RTX_NIB_W-1:0]  x_o,
  output logic      [rtx_pkg::RTX_NIB_W-1:0]  y_o,
  output logic      [rtx_pkg::RTX_Z_W-1:0]    z_o,
  output logic      [rtx_pkg::RTX_E_W-1:0]    e_o,
  output logic      [rtx_pkg::RTX_ADDR_W-1:0] data_pointer_o,
  output logic                                ram_we_o,
  output logic      [rtx_pkg::RTX_ADDR_W-1:0] ram_waddr_o,
  output logic      [rtx_pkg::RTX_NIB_W-1:0]  ram_wdata_o,
  output logic                                skip_pending_o
);
  import rtx_pkg::*;

  if (NIB_W != RTX_NIB_W) begin : g_width_check
    $error("rtx_core serves only 4-bit data nibbles");
  end

  // ==========================================================================
  // Decode
  rtx_dec_if dec_bus ();
  assign dec_bus.instr = instr_i;

  rtx_decode u_decode (
    .bus (dec_bus)
  );

  // ==========================================================================
  // State
  logic [RTX_NIB_W-1:0]  acc_r, acc_nxt;
  logic [RTX_NIB_W-1:0]  b_r, b_nxt;
  logic [RTX_NIB_W-1:0]  x_r, x_nxt;
  logic [RTX_NIB_W-1:0]  y_r, y_nxt;
  logic [RTX_Z_W-1:0]    z_r, z_nxt;
  logic [RTX_E_W-1:0]    e_r, e_nxt;
  logic                  we_r, we_nxt;
  logic [RTX_ADDR_W-1:0] waddr_r, waddr_nxt;
  logic [RTX_NIB_W-1:0]  wdata_r, wdata_nxt;
  logic                  skip_r, skip_nxt;
  logic                  pair_run_r, pair_run_nxt;
  logic                  execute;
  logic                  y_inc, y_dec, y_skip;
  logic [RTX_NIB_W-1:0]  y_stepped;
  rtx_op_type            op;
  logic [RTX_NIB_W-1:0]  imm;
  logic [RTX_NIB_W-1:0]  ram_word;

  assign op  = dec_bus.op;
  assign imm = dec_bus.imm;

  // A skipped word, and a pair load that follows another pair load, do nothing.
  assign execute = instr_valid_i && !skip_r
                   && !(op == RTX_OP_LOAD_X_Y && pair_run_r);

  assign y_inc = execute && (op == RTX_OP_INC_Y || op == RTX_OP_RAM_XINC);
  assign y_dec = execute && (op == RTX_OP_DEC_Y || op == RTX_OP_RAM_XDEC);

  rtx_y_step u_y_step (
    .y_i    (y_r),
    .inc_i  (y_inc),
    .dec_i  (y_dec),
    .y_o    (y_stepped),
    .skip_o (y_skip)
  );

  // ==========================================================================
  // Read data
  // A write still waiting in the output register is newer than the RAM word.
  assign ram_word = (we_r && waddr_r == {z_r, x_r, y_r}) ? wdata_r : ram_rdata_i;

  // ==========================================================================
  // Next state
  always_comb begin
    acc_nxt      = acc_r;
    b_nxt        = b_r;
    x_nxt        = x_r;
    y_nxt        = y_stepped;
    z_nxt        = z_r;
    e_nxt        = e_r;
    we_nxt       = 1'b0;
    waddr_nxt    = waddr_r;
    wdata_nxt    = wdata_r;
    skip_nxt     = skip_r;
    pair_run_nxt = pair_run_r;
    if (instr_valid_i) begin
      // Every valid word, skipped or not, updates the skip and pair-run flags.
      skip_nxt     = y_skip;
      pair_run_nxt = (op == RTX_OP_LOAD_X_Y);
    end
    if (execute) begin
      case (op)
        RTX_OP_B_TO_ACC: begin
          acc_nxt = b_r;
        end
        RTX_OP_ACC_TO_B: begin
          b_nxt = acc_r;
        end
        RTX_OP_Y_TO_ACC: begin
          acc_nxt = y_r;
        end
        RTX_OP_ACC_TO_Y: begin
          y_nxt = acc_r;
        end
        RTX_OP_PAIR_TO_E: begin
          e_nxt = {b_r, acc_r};
        end
        RTX_OP_E_TO_PAIR: begin
          b_nxt   = e_r[7:4];
          acc_nxt = e_r[3:0];
        end
        RTX_OP_Z_TO_ACC: begin
          acc_nxt = {2'h0, z_r};
        end
        RTX_OP_X_TO_ACC: begin
          acc_nxt = x_r;
        end
        RTX_OP_SP_TO_ACC: begin
          acc_nxt = {1'h0, stack_ptr_i};
        end
        RTX_OP_LOAD_X_Y: begin
          x_nxt = instr_i[7:4];
          y_nxt = instr_i[3:0];
        end
        RTX_OP_LOAD_Z: begin
          z_nxt = instr_i[1:0];
        end
        RTX_OP_RAM_LOAD: begin
          acc_nxt = ram_word;
          x_nxt   = x_r ^ imm;
        end
        RTX_OP_RAM_XCHG, RTX_OP_RAM_XDEC, RTX_OP_RAM_XINC: begin
          // The write lands one cycle later at the address of this cycle.
          acc_nxt   = ram_word;
          we_nxt    = 1'b1;
          waddr_nxt = {z_r, x_r, y_r};
          wdata_nxt = acc_r;
          x_nxt     = x_r ^ imm;
        end
        RTX_OP_RAM_STORE: begin
          we_nxt    = 1'b1;
          waddr_nxt = {z_r, x_r, y_r};
          wdata_nxt = acc_r;
          x_nxt     = x_r ^ imm;
        end
        default: begin
          acc_nxt = acc_r;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_r      <= RTX_NIB_RESET;
      b_r        <= RTX_NIB_RESET;
      x_r        <= RTX_NIB_RESET;
      y_r        <= RTX_NIB_RESET;
      z_r        <= RTX_Z_RESET;
      e_r        <= RTX_E_RESET;
      we_r       <= 1'b0;
      waddr_r    <= '0;
      wdata_r    <= RTX_NIB_RESET;
      skip_r     <= 1'b0;
      pair_run_r <= 1'b0;
    end else begin
      acc_r      <= acc_nxt;
      b_r        <= b_nxt;
      x_r        <= x_nxt;
      y_r        <= y_nxt;
      z_r        <= z_nxt;
      e_r        <= e_nxt;
      we_r       <= we_nxt;
      waddr_r    <= waddr_nxt;
      wdata_r    <= wdata_nxt;
      skip_r     <= skip_nxt;
      pair_run_r <= pair_run_nxt;
    end
  end

  assign acc_o          = acc_r;
  assign b_o            = b_r;
  assign x_o            = x_r;
  assign y_o            = y_r;
  assign z_o            = z_r;
  assign e_o            = e_r;
  assign data_pointer_o = {z_r, x_r, y_r};
  assign ram_we_o       = we_r;
  assign ram_waddr_o    = waddr_r;
  assign ram_wdata_o    = wdata_r;
  assign skip_pending_o = skip_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_run(rtx_op_type o);
    execute && op == o;
  endsequence

  sequence s_pair_then_pair;
    instr_valid_i && op == RTX_OP_LOAD_X_Y ##1 instr_valid_i && op == RTX_OP_LOAD_X_Y;
  endsequence

  a_z_to_acc: assert property (s_run(RTX_OP_Z_TO_ACC) |=> acc_r == {2'h0, $past(z_r)})
    else $error("Z move did not zero-extend into the accumulator");
  a_x_to_acc: assert property (s_run(RTX_OP_X_TO_ACC) |=> acc_r == $past(x_r) && x_r == $past(x_r))
    else $error("X move did not copy X");
  a_sp_to_acc: assert property (s_run(RTX_OP_SP_TO_ACC) |=> acc_r == {1'b0, $past(stack_ptr_i)})
    else $error("Stack pointer read left bit 3 set");
  a_pair_load: assert property (s_run(RTX_OP_LOAD_X_Y) |=> {x_r, y_r} == $past(instr_i[7:0]))
    else $error("Pair load wrote wrong X or Y");
  a_pair_run_hold: assert property (s_pair_then_pair |=> $stable(x_r) && $stable(y_r))
    else $error("Second consecutive pair load was executed");
  a_inc_skip: assert property (s_run(RTX_OP_INC_Y) |=> skip_r == (y_r == RTX_Y_INC_SKIP))
    else $error("Increment skip flag does not match Y");
  a_dec_wrap: assert property (s_run(RTX_OP_RAM_XDEC) |=> y_r == $past(y_r) - 4'h1 && skip_r == (y_r == 4'hF))
    else $error("Exchange decrement did not step Y or skip");
  a_xchg_swap: assert property (s_run(RTX_OP_RAM_XCHG) |=>
                                ram_we_o && ram_wdata_o == $past(acc_r) && acc_r == $past(ram_word)
                                && x_r == ($past(x_r) ^ $past(imm)))
    else $error("RAM exchange did not swap or update X");
  a_store_once: assert property (s_run(RTX_OP_RAM_STORE) |=>
                                 ram_we_o && ram_wdata_o == $past(acc_r) && $stable(acc_r)
                                 && x_r == ($past(x_r) ^ $past(imm)) ##1 (!ram_we_o || $past(execute)))
    else $error("RAM store strobe wrong");
  a_skip_kills: assert property (instr_valid_i && skip_r |=> !ram_we_o && !skip_r)
    else $error("Skipped word had an effect");
  a_pair_to_e: assert property (s_run(RTX_OP_PAIR_TO_E) |=> e_r == {$past(b_r), $past(acc_r)})
    else $error("Pair to E move wrong");

  // A load that reads the word of a write still pending must see the new value.
  sequence s_pending_hit;
    ram_we_o && ram_waddr_o == data_pointer_o;
  endsequence

  a_load_z: assert property (s_run(RTX_OP_LOAD_Z) |=> z_r == $past(instr_i[1:0]))
    else $error("Z immediate load wrote wrong value");
  a_inc_step: assert property (s_run(RTX_OP_INC_Y) |=> y_r == $past(y_r) + 4'h1)
    else $error("Y increment did not add one");
  a_dec_step: assert property (s_run(RTX_OP_DEC_Y) |=> y_r == $past(y_r) - 4'h1 && skip_r == (y_r == RTX_Y_DEC_SKIP))
    else $error("Y decrement did not step Y or skip");

  a_ram_load: assert property (s_run(RTX_OP_RAM_LOAD) |=>
                               acc_r == $past(ram_word) && x_r == ($past(x_r) ^ $past(imm)))
    else $error("RAM load did not fill the accumulator or update X");
  a_ram_forward: assert property (s_run(RTX_OP_RAM_LOAD) ##0 s_pending_hit |=>
                                  acc_r == $past(ram_wdata_o))
    else $error("RAM load missed the pending write");
  a_xinc_step: assert property (s_run(RTX_OP_RAM_XINC) |=>
                                ram_we_o && y_r == $past(y_r) + 4'h1 && skip_r == (y_r == RTX_Y_INC_SKIP)
                                && x_r == ($past(x_r) ^ $past(imm)))
    else $error("Exchange increment did not step Y or skip");

  a_b_to_acc: assert property (s_run(RTX_OP_B_TO_ACC) |=> acc_r == $past(b_r) && $stable(b_r))
    else $error("B move did not copy B");
  a_acc_to_b: assert property (s_run(RTX_OP_ACC_TO_B) |=> b_r == $past(acc_r) && $stable(acc_r))
    else $error("Accumulator to B move wrong");
  a_y_to_acc: assert property (s_run(RTX_OP_Y_TO_ACC) |=> acc_r == $past(y_r))
    else $error("Y move did not copy Y");
  a_acc_to_y: assert property (s_run(RTX_OP_ACC_TO_Y) |=> y_r == $past(acc_r) && !skip_r)
    else $error("Accumulator to Y move wrong");
  a_e_to_pair: assert property (s_run(RTX_OP_E_TO_PAIR) |=> {b_r, acc_r} == $past(e_r))
    else $error("E to pair move wrong");

  a_idle_hold: assert property (!instr_valid_i |=>
                                $stable(acc_r) && $stable(x_r) && $stable(y_r) && $stable(skip_r) && !ram_we_o)
    else $error("State changed in a cycle without an instruction");
endmodule
`default_nettype wire

//--- verilog/rtx_dec_if.sv
// Carries one instruction word to the decoder and the decoded operation back.
// Assumes both ends sit in the same clock domain; the path is combinational.
`timescale 1ns/1ps
`default_nettype none
interface rtx_dec_if;
  import rtx_pkg::*;
  logic [RTX_INSTR_W-1:0] instr;
  rtx_op_type             op;
  logic [RTX_NIB_W-1:0]   imm;
  modport dec (input instr, output op, output imm);
  modport exe (output instr, input op, input imm);
endinterface
`default_nettype wire

//--- verilog/rtx_decode.sv
// Combinational decoder for the transfer instruction group.
// Assumes the word on the interface is the instruction of the current cycle.
`timescale 1ns/1ps
`default_nettype none
module rtx_decode (
  rtx_dec_if.dec bus
);
  import rtx_pkg::*;

  always_comb begin
    bus.op  = RTX_OP_NONE;
    bus.imm = bus.instr[3:0];
    if (bus.instr[9:8] == RTX_PFX_LOAD_X_Y) begin
      bus.op = RTX_OP_LOAD_X_Y;
    end else if (bus.instr[9:2] == RTX_PFX_LOAD_Z) begin
      bus.op = RTX_OP_LOAD_Z;
    end else if (bus.instr[9:4] == RTX_PFX_RAM_LOAD) begin
      bus.op = RTX_OP_RAM_LOAD;
    end else if (bus.instr[9:4] == RTX_PFX_RAM_XCHG) begin
      bus.op = RTX_OP_RAM_XCHG;
    end else if (bus.instr[9:4] == RTX_PFX_RAM_XDEC) begin
      bus.op = RTX_OP_RAM_XDEC;
    end else if (bus.instr[9:4] == RTX_PFX_RAM_XINC) begin
      bus.op = RTX_OP_RAM_XINC;
    end else if (bus.instr[9:4] == RTX_PFX_RAM_STORE) begin
      bus.op = RTX_OP_RAM_STORE;
    end else if (bus.instr == RTX_OPC_MOVE_B_TO_ACC) begin
      bus.op = RTX_OP_B_TO_ACC;
    end else if (bus.instr == RTX_OPC_MOVE_ACC_TO_B) begin
      bus.op = RTX_OP_ACC_TO_B;
    end else if (bus.instr == RTX_OPC_MOVE_Y_TO_ACC) begin
      bus.op = RTX_OP_Y_TO_ACC;
    end else if (bus.instr == RTX_OPC_MOVE_ACC_TO_Y) begin
      bus.op = RTX_OP_ACC_TO_Y;
    end else if (bus.instr == RTX_OPC_MOVE_PAIR_TO_E) begin
      bus.op = RTX_OP_PAIR_TO_E;
    end else if (bus.instr == RTX_OPC_MOVE_E_TO_PAIR) begin
      bus.op = RTX_OP_E_TO_PAIR;
    end else if (bus.instr == RTX_OPC_MOVE_Z_TO_ACC) begin
      bus.op = RTX_OP_Z_TO_ACC;
    end else if (bus.instr == RTX_OPC_MOVE_X_TO_ACC) begin
      bus.op = RTX_OP_X_TO_ACC;
    end else if (bus.instr == RTX_OPC_MOVE_SP_TO_ACC) begin
      bus.op = RTX_OP_SP_TO_ACC;
    end else if (bus.instr == RTX_OPC_INCREMENT_Y) begin
      bus.op = RTX_OP_INC_Y;
    end else if (bus.instr == RTX_OPC_DECREMENT_Y) begin
      bus.op = RTX_OP_DEC_Y;
    end
  end
endmodule
`default_nettype wire

//--- verilog/rtx_pkg.sv
// Shared constants and types for the register and RAM transfer execution unit.
// Assumes a 10-bit instruction word and 4-bit data nibbles.
`default_nettype none
package rtx_pkg;
  // ==========================================================================
  // Widths
  localparam int RTX_INSTR_W = 10;
  localparam int RTX_NIB_W   = 4;
  localparam int RTX_E_W     = 8;
  localparam int RTX_Z_W     = 2;
  localparam int RTX_SP_W    = 3;
  localparam int RTX_ADDR_W  = RTX_Z_W + 2 * RTX_NIB_W;

  // ==========================================================================
  // Full opcodes
  localparam logic [9:0] RTX_OPC_MOVE_B_TO_ACC  = 10'h01E;
  localparam logic [9:0] RTX_OPC_MOVE_ACC_TO_B  = 10'h00E;
  localparam logic [9:0] RTX_OPC_MOVE_Y_TO_ACC  = 10'h01F;
  localparam logic [9:0] RTX_OPC_MOVE_ACC_TO_Y  = 10'h00C;
  localparam logic [9:0] RTX_OPC_MOVE_PAIR_TO_E = 10'h01A;
  localparam logic [9:0] RTX_OPC_MOVE_E_TO_PAIR = 10'h02A;
  localparam logic [9:0] RTX_OPC_MOVE_Z_TO_ACC  = 10'h053;
  localparam logic [9:0] RTX_OPC_MOVE_X_TO_ACC  = 10'h052;
  localparam logic [9:0] RTX_OPC_MOVE_SP_TO_ACC = 10'h050;
  localparam logic [9:0] RTX_OPC_INCREMENT_Y    = 10'h013;
  localparam logic [9:0] RTX_OPC_DECREMENT_Y    = 10'h017;

  // ==========================================================================
  // Opcode prefixes of the forms that carry an immediate
  localparam logic [1:0] RTX_PFX_LOAD_X_Y  = 2'h3;
  localparam logic [7:0] RTX_PFX_LOAD_Z    = 8'h12;
  localparam logic [5:0] RTX_PFX_RAM_LOAD  = 6'h2C;
  localparam logic [5:0] RTX_PFX_RAM_XCHG  = 6'h2D;
  localparam logic [5:0] RTX_PFX_RAM_XINC  = 6'h2E;
  localparam logic [5:0] RTX_PFX_RAM_XDEC  = 6'h2F;
  localparam logic [5:0] RTX_PFX_RAM_STORE = 6'h2B;

  // ==========================================================================
  // Skip conditions and reset values
  localparam logic [3:0] RTX_Y_INC_SKIP = 4'h0;
  localparam logic [3:0] RTX_Y_DEC_SKIP = 4'hF;
  localparam logic [3:0] RTX_NIB_RESET  = 4'h0;
  localparam logic [7:0] RTX_E_RESET    = 8'h00;
  localparam logic [1:0] RTX_Z_RESET    = 2'h0;

  typedef enum logic [4:0] {
    RTX_OP_NONE        = 5'h00,
    RTX_OP_B_TO_ACC    = 5'h01,
    RTX_OP_ACC_TO_B    = 5'h02,
    RTX_OP_Y_TO_ACC    = 5'h03,
    RTX_OP_ACC_TO_Y    = 5'h04,
    RTX_OP_PAIR_TO_E   = 5'h05,
    RTX_OP_E_TO_PAIR   = 5'h06,
    RTX_OP_Z_TO_ACC    = 5'h07,
    RTX_OP_X_TO_ACC    = 5'h08,
    RTX_OP_SP_TO_ACC   = 5'h09,
    RTX_OP_LOAD_X_Y    = 5'h0A,
    RTX_OP_LOAD_Z      = 5'h0B,
    RTX_OP_INC_Y       = 5'h0C,
    RTX_OP_DEC_Y       = 5'h0D,
    RTX_OP_RAM_LOAD    = 5'h0E,
    RTX_OP_RAM_XCHG    = 5'h0F,
    RTX_OP_RAM_XDEC    = 5'h10,
    RTX_OP_RAM_XINC    = 5'h11,
    RTX_OP_RAM_STORE   = 5'h12
  } rtx_op_type;
endpackage
`default_nettype wire

//--- verilog/rtx_y_step.sv
// Increment and decrement of register Y with the skip outcome.
// Assumes at most one of the two requests is high.
`timescale 1ns/1ps
`default_nettype none
module rtx_y_step (
  input  wire logic [rtx_pkg::RTX_NIB_W-1:0] y_i,
  input  wire logic                          inc_i,
  input  wire logic                          dec_i,
  output logic      [rtx_pkg::RTX_NIB_W-1:0] y_o,
  output logic                               skip_o
);
  import rtx_pkg::*;

  always_comb begin
    y_o    = y_i;
    skip_o = 1'b0;
    if (inc_i) begin
      y_o    = y_i + 4'h1;
      skip_o = (y_o == RTX_Y_INC_SKIP);
    end else if (dec_i) begin
      y_o    = y_i - 4'h1;
      skip_o = (y_o == RTX_Y_DEC_SKIP);
    end
  end
endmodule
`default_nettype wire
